// ===== src/adc_control_and_result_regs.sv
// Converter control and result registers behind an AXI4-Lite slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

// Summary of operation
// - Clock select code picks system clock divided by 2, 8 or 32.
// - Clock select bits 2 to 6 always read zero.
// - Channel select code n routes analog input n to the converter.
// - Config code k makes lowest k lines analog; code 7 makes all eight.
// - Config code zero keeps all lines digital and powers the converter down.
// - Done flag reads 1 while a conversion is pending, 0 when finished.
// - Rising start bit resets the converter and sets the done flag.
// - Conversion begins on the falling start bit after a full 0-1-0.
// - High result holds bits 11..4; low holds bits 3..0 in its top nibble.
// - Every finished conversion sets the interrupt request flag.
// - Analog lines have digital function and pull-up disabled.
module adc_control_and_result_regs #(
	parameter int CONV_CLKS = 14,
	parameter int RES_W     = 12
) (
	input  wire logic                      ref_clk_i,
	input  wire logic                      reset_i,
	// AXI4-Lite write address
	input  wire logic [31:0]               s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0]               s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Analog core side
	output adc_ctrl_pkg::analog_req_s      analog_req_o,
	input  wire logic [RES_W-1:0]          analog_result_i,
	output logic [7:0]                     portb_analog_o,
	output logic [7:0]                     portb_pullup_en_o,
	output logic                           test_mode_o,
	output logic                           irq_o
);
	localparam int CNT_W = $clog2(CONV_CLKS + 1);
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CLKS - 1);

	adc_ctrl_pkg::control_s    ctrl_q;
	adc_ctrl_pkg::clk_div_e    div_sel_q;
	adc_ctrl_pkg::conv_state_e state_q;
	logic                      test_q;
	logic [RES_W-1:0]          result_q;
	logic [CNT_W-1:0]          conv_cnt_q;
	logic                      irq_stat_q;
	logic                      irq_mask_q;
	logic                      conv_tick;
	logic                      conv_done;
	logic                      start_rise;
	logic                      start_fall;
	logic                      power_on;

	// Write channel capture; address and data may arrive in either order
	logic                      aw_held_q;
	logic                      w_held_q;
	logic [7:0]                wdata_q;
	logic                      wstrb0_q;
	logic                      wr_fire;
	logic                      wr_hit;
	logic                      wr_ctrl;
	logic                      start_new;
	logic [7:0]                ar_idx;
	logic [7:0]                rd_byte;
	logic                      rd_hit;
	logic                      rd_fire;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

	// Each channel stays held until both are in and the response fires
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			wdata_q   <= `ZERO8;
			wstrb0_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Printed offsets are register indices; byte address is four times index
	function automatic logic [7:0] addr_to_idx(input logic [31:0] a);
		addr_to_idx = a[`REG_IDX_MSB:`REG_IDX_LSB];
	endfunction

	function automatic logic idx_valid(input logic [31:0] a);
		idx_valid = (a[1:0] == 2'b00) && (a[31:`REG_IDX_MSB+1] == '0)
			&& (addr_to_idx(a) >= `OFS_RESULT_LOW) && (addr_to_idx(a) <= `OFS_IRQ_MASK);
	endfunction

	// Full write address, kept for decode and the range check
	logic [31:0] aw_addr_q;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			aw_addr_q <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_q <= s_axi_awaddr;
		end
	end

	// Write decode from the held address
	assign wr_hit    = idx_valid(aw_addr_q);
	assign wr_ctrl   = wr_fire && wr_hit && wstrb0_q
		&& (addr_to_idx(aw_addr_q) == `OFS_CONTROL);
	assign start_new = wdata_q[`CTRL_START_BIT];

	// Write response; unmapped offsets get SLVERR, read-only ones are ignored
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Start edges seen from the written value
	assign start_rise = wr_ctrl && start_new && !ctrl_q.start;
	assign start_fall = wr_ctrl && !start_new && ctrl_q.start;

	// Control register; software writes every field but the done flag
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q.start       <= 1'b0;
			ctrl_q.done_n      <= 1'b1;
			ctrl_q.portb_cfg   <= `CFG_ALL_DIGITAL;
			ctrl_q.channel_sel <= 3'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q.start       <= start_new;
				ctrl_q.portb_cfg   <= wdata_q[`CTRL_CFG_MSB:`CTRL_CFG_LSB];
				ctrl_q.channel_sel <= wdata_q[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
			end
			// A restart on the completing edge keeps the flag set
			if (start_rise) begin
				ctrl_q.done_n <= 1'b1;
			end else if (conv_done) begin
				ctrl_q.done_n <= 1'b0;
			end
		end
	end

	// Clock select register; bits 2..6 are not stored
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			div_sel_q <= adc_ctrl_pkg::DIV_2;
			test_q    <= 1'b0;
		end else if (wr_fire && wr_hit && wstrb0_q
			&& addr_to_idx(aw_addr_q) == `OFS_CLOCK_SELECT) begin
			div_sel_q <= adc_ctrl_pkg::clk_div_e'(wdata_q[`CSEL_DIV_MSB:`CSEL_DIV_LSB]);
			test_q    <= wdata_q[`CSEL_TEST_BIT]; // test use only
		end
	end
	assign test_mode_o = test_q;

	// Converter powered only when some port B line is analog
	assign power_on = (ctrl_q.portb_cfg != `CFG_ALL_DIGITAL);

	// Divider runs only while converting, so each start sees a fresh phase
	conv_clk_div #(
		.CNT_W (5)
	) u_div (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.run_i     (power_on && state_q == adc_ctrl_pkg::CONV_BUSY),
		.div_sel_i (div_sel_q), // code 3 runs as code 0
		.tick_o    (conv_tick)
	);

	assign conv_done = (state_q == adc_ctrl_pkg::CONV_BUSY) && conv_tick
		&& (conv_cnt_q == CONV_LAST);

	// Conversion sequencer: rise arms and resets, fall starts, count ends
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q    <= adc_ctrl_pkg::CONV_IDLE;
			conv_cnt_q <= '0;
		end else begin
			case (state_q)
				adc_ctrl_pkg::CONV_IDLE: begin
					if (start_rise) begin
						state_q <= adc_ctrl_pkg::CONV_ARMED;
					end
				end
				adc_ctrl_pkg::CONV_ARMED: begin
					if (start_fall) begin
						state_q    <= adc_ctrl_pkg::CONV_BUSY;
						conv_cnt_q <= '0;
					end
				end
				adc_ctrl_pkg::CONV_BUSY: begin
					if (start_rise) begin
						state_q <= adc_ctrl_pkg::CONV_ARMED; // Restart aborts
					end else if (conv_done) begin
						state_q <= adc_ctrl_pkg::CONV_IDLE;
					end else if (conv_tick) begin
						conv_cnt_q <= conv_cnt_q + 1'b1;
					end
				end
				default: begin
					state_q <= adc_ctrl_pkg::CONV_IDLE;
				end
			endcase
		end
	end

	// Result captured on the same edge the flag clears
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			result_q <= '0;
		end else if (conv_done) begin
			result_q <= analog_result_i;
		end
	end

	// Sticky interrupt status, cleared by reading it; a new event wins
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_stat_q <= 1'b0;
		end else if (conv_done) begin
			irq_stat_q <= 1'b1;
		end else if (rd_fire && rd_hit && ar_idx == `OFS_IRQ_STATUS) begin
			irq_stat_q <= 1'b0;
		end
	end

	// Interrupt mask, bit 0 only
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_mask_q <= 1'b0;
		end else if (wr_fire && wr_hit && wstrb0_q
			&& addr_to_idx(aw_addr_q) == `OFS_IRQ_MASK) begin
			irq_mask_q <= wdata_q[0];
		end
	end
	assign irq_o = irq_stat_q && irq_mask_q;

	// Analog requests towards the converter core
	assign analog_req_o.power_on   = power_on;
	assign analog_req_o.core_reset = (state_q == adc_ctrl_pkg::CONV_ARMED);
	assign analog_req_o.sample     = (state_q == adc_ctrl_pkg::CONV_BUSY);
	assign analog_req_o.channel    = ctrl_q.channel_sel;

	// Port B analog mask: lowest k lines, or all eight for code 7
	always_comb begin
		if (ctrl_q.portb_cfg == `CFG_ALL_ANALOG) begin
			portb_analog_o = 8'hFF;
		end else begin
			portb_analog_o = 8'((9'h001 << ctrl_q.portb_cfg) - 9'h001);
		end
	end
	assign portb_pullup_en_o = ~portb_analog_o;

	// Read path: one read at a time, answered one cycle after the address
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign ar_idx        = addr_to_idx(s_axi_araddr);
	assign rd_hit        = idx_valid(s_axi_araddr);

	always_comb begin
		case (ar_idx)
			`OFS_RESULT_LOW:   rd_byte = {result_q[3:0], 4'h0};
			`OFS_RESULT_HIGH:  rd_byte = result_q[11:4];
			`OFS_CONTROL:      rd_byte = ctrl_q;
			`OFS_CLOCK_SELECT: rd_byte = {test_q, 5'h00, div_sel_q};
			`OFS_IRQ_STATUS:   rd_byte = {7'h00, irq_stat_q};
			`OFS_IRQ_MASK:     rd_byte = {7'h00, irq_mask_q};
			default:           rd_byte = `ZERO8;
		endcase
	end

	// Read answer; data stand until rready is seen
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== shared/adc_ctrl_defines.svh
// Register offsets, field positions and reset values for the converter control block
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define OFS_RESULT_LOW      8'h20
`define OFS_RESULT_HIGH     8'h21
`define OFS_CONTROL         8'h22
`define OFS_CLOCK_SELECT    8'h23
`define OFS_IRQ_STATUS      8'h24
`define OFS_IRQ_MASK        8'h25
`define REG_IDX_LSB         2
`define REG_IDX_MSB         9
`define CTRL_CHAN_LSB       0
`define CTRL_CHAN_MSB       2
`define CTRL_CFG_LSB        3
`define CTRL_CFG_MSB        5
`define CTRL_DONE_N_BIT     6
`define CTRL_START_BIT      7
`define CSEL_DIV_LSB        0
`define CSEL_DIV_MSB        1
`define CSEL_TEST_BIT       7
`define CFG_ALL_ANALOG      3'h7
`define CFG_ALL_DIGITAL     3'h0
`define HALF_DIV2           5'h00
`define HALF_DIV8           5'h03
`define HALF_DIV32          5'h0F
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define ZERO8               8'h00

`endif

// ===== shared/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		DIV_2   = 2'h0,
		DIV_8   = 2'h1,
		DIV_32  = 2'h2,
		DIV_UND = 2'h3
	} clk_div_e;

	typedef enum logic [1:0] {
		CONV_IDLE  = 2'h0,
		CONV_ARMED = 2'h1,
		CONV_BUSY  = 2'h2
	} conv_state_e;

	// Control register fields
	typedef struct packed {
		logic       start;
		logic       done_n;
		logic [2:0] portb_cfg;
		logic [2:0] channel_sel;
	} control_s;

	// Request to the analog core
	typedef struct packed {
		logic       power_on;
		logic       core_reset;
		logic       sample;
		logic [2:0] channel;
	} analog_req_s;
endpackage

// ===== src/conv_clk_div.sv
// Converter clock tick generator divided from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"

module conv_clk_div #(
	parameter int CNT_W = 5
) (
	input  wire logic                     ref_clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     run_i,
	input  wire adc_ctrl_pkg::clk_div_e   div_sel_i,
	output logic                          tick_o
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] half_limit;
	logic             phase_q;

	// Half period in system cycles minus one
	always_comb begin
		case (div_sel_i)
			adc_ctrl_pkg::DIV_2:  half_limit = `HALF_DIV2;
			adc_ctrl_pkg::DIV_8:  half_limit = `HALF_DIV8;
			adc_ctrl_pkg::DIV_32: half_limit = `HALF_DIV32;
			default:              half_limit = `HALF_DIV2; // never stalls
		endcase
	end

	// Counter and phase; tick marks one full converter clock period
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !run_i) begin
			cnt_q   <= '0;
			phase_q <= 1'b0;
		end else if (cnt_q >= half_limit) begin
			cnt_q   <= '0;
			phase_q <= ~phase_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign tick_o = run_i && phase_q && (cnt_q >= half_limit);
endmodule
`default_nettype wire

// ===== verif/adc_ctrl_props.sv
// Port-level checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props (
	input wire logic                      ref_clk_i,
	input wire logic                      reset_i,
	input wire logic                      s_axi_awvalid,
	input wire logic                      s_axi_awready,
	input wire logic                      s_axi_wvalid,
	input wire logic                      s_axi_wready,
	input wire logic [1:0]                s_axi_bresp,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	input wire adc_ctrl_pkg::analog_req_s analog_req_o,
	input wire logic [7:0]                portb_analog_o,
	input wire logic [7:0]                portb_pullup_en_o
);
	// One clock domain, so defaults keep each property short
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	a_pullup_off: assert property (portb_pullup_en_o == ~portb_analog_o)
		else $error("pull-up left on an analog line");
	a_analog_mask: assert property (((portb_analog_o + 8'h01) & portb_analog_o) == 8'h00
		&& portb_analog_o != 8'h7F) else $error("analog lines not a low contiguous run");
	a_power_follow: assert property (analog_req_o.power_on == (portb_analog_o != 8'h00))
		else $error("converter power does not follow line config");
	a_arm_no_sample: assert property ($rose(analog_req_o.core_reset) |->
		!analog_req_o.sample) else $error("sampling while converter held in reset");
	a_sample_after_arm: assert property ($rose(analog_req_o.sample) |->
		$past(analog_req_o.core_reset)) else $error("conversion began without prior arm");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module tb;
	logic                      ref_clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                      s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic                      s_axi_arready, s_axi_rvalid, s_axi_rready, irq_o, test_mode_o;
	logic [31:0]               s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]                s_axi_wstrb;
	logic [1:0]                s_axi_bresp, s_axi_rresp;
	logic [11:0]               analog_result_i;
	logic [7:0]                portb_analog_o, portb_pullup_en_o;
	adc_ctrl_pkg::analog_req_s analog_req_o;
	int                        fails, n_tests;
	logic [31:0]               seed = 32'h0000004A;

	// Short conversion so every clock code finishes quickly
	localparam int CONV = 2;
	adc_control_and_result_regs #(.CONV_CLKS(CONV)) dut_u (.ref_clk_i, .reset_i, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .analog_req_o, .analog_result_i, .portb_analog_o,
		.portb_pullup_en_o, .test_mode_o, .irq_o);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Lowest k lines analog, code 7 all eight
	function automatic logic [7:0] pb(input logic [2:0] k);
		return (k == 3'h7) ? 8'hFF : 8'((16'h1 << k) - 16'h1);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Payload held until each channel's own ready edge
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge ref_clk_i); // Idle edge: back-to-back calls never re-raise in one step
		s_axi_awaddr <= {22'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			t++;
		end while (!s_axi_bvalid && t < 200);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bvalid), 32'h1);
		chk(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge ref_clk_i); // Idle edge: back-to-back calls never re-raise in one step
		s_axi_araddr <= {22'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			t++;
		end while (!s_axi_rvalid && t < 200);
		s_axi_rready <= 1'b0;
		chk(32'(s_axi_rvalid), 32'h1);
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
	endtask

	task automatic pchk(input logic [2:0] k);
		chk(32'({analog_req_o.power_on, portb_analog_o, portb_pullup_en_o}),
			32'({k != 3'h0, pb(k), ~pb(k)}));
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Free-running system clock, 4 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// Generous span: a slow conversion is 64 cycles
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		fails++;
		results();
	end

	// Main sequence
	initial begin
		logic [31:0] v;
		logic [2:0]  cfg, ch;
		int          t, p;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'h1;
		analog_result_i = 12'h000;
		reset_i = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		@(posedge ref_clk_i);
		rd(`OFS_CONTROL, 32'h40, `RESP_OKAY);
		pchk(3'h0);
		wr(`OFS_CLOCK_SELECT, 8'hFF, `RESP_OKAY);
		rd(`OFS_CLOCK_SELECT, 32'h83, `RESP_OKAY);
		chk(32'(test_mode_o), 32'h1);
		rd(8'h30, 32'h0, `RESP_SLVERR);
		wr(8'h30, 8'h00, `RESP_SLVERR);
		wr(`OFS_RESULT_HIGH, 8'hAB, `RESP_OKAY);
		rd(`OFS_RESULT_HIGH, 32'h0, `RESP_OKAY);
		// Lane 0 strobe off: the write is answered but not applied
		s_axi_wstrb <= 4'h0;
		wr(`OFS_IRQ_MASK, 8'h01, `RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			v = xs();
			cfg = (v[5:3] == 3'h0) ? 3'h7 : v[5:3];
			ch = v[2:0];
			analog_result_i <= v[27:16];
			wr(`OFS_CLOCK_SELECT, {6'h0, i[1:0]}, `RESP_OKAY);
			wr(`OFS_IRQ_MASK, {7'h0, i[0]}, `RESP_OKAY);
			wr(`OFS_CONTROL, {2'h0, cfg, ch}, `RESP_OKAY);
			chk(32'(analog_req_o.sample), 32'h0);
			pchk(cfg);
			// Start pulse follows the config change at once
			wr(`OFS_CONTROL, {2'h2, cfg, ch}, `RESP_OKAY);
			chk(32'({analog_req_o.core_reset, analog_req_o.sample}), 32'h2);
			rd(`OFS_CONTROL, {24'h0, 2'h3, cfg, ch}, `RESP_OKAY);
			wr(`OFS_CONTROL, {2'h0, cfg, ch}, `RESP_OKAY);
			chk(32'({analog_req_o.sample, analog_req_o.channel}), 32'({1'b1, ch}));
			t = 0;
			while (analog_req_o.sample && t < 200) begin
				@(posedge ref_clk_i);
				t++;
			end
			p = (i[1:0] == 2'h1) ? 8 : (i[1:0] == 2'h2) ? 32 : 2;
			// Count starts an edge after the fall lands and ends an edge after done
			chk(32'(t), 32'(CONV * p));
			rd(`OFS_CONTROL, {24'h0, 2'h0, cfg, ch}, `RESP_OKAY);
			chk(32'(irq_o), 32'(i[0]));
			rd(`OFS_RESULT_HIGH, {24'h0, v[27:20]}, `RESP_OKAY);
			rd(`OFS_RESULT_LOW, {24'h0, v[19:16], 4'h0}, `RESP_OKAY);
			rd(`OFS_IRQ_STATUS, 32'h1, `RESP_OKAY);
			rd(`OFS_IRQ_STATUS, 32'h0, `RESP_OKAY);
			chk(32'(irq_o), 32'h0);
		end
		wr(`OFS_CONTROL, 8'h00, `RESP_OKAY);
		pchk(3'h0);
		results();
	end
endmodule

bind adc_control_and_result_regs adc_ctrl_props chk_u (.ref_clk_i, .reset_i, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .analog_req_o, .portb_analog_o, .portb_pullup_en_o);
`default_nettype wire
